// *** hdl/fts_pkg.sv ***
// Contract
// - Idle, read or volatile reset: 40 ns recovery
// - Array operation hit by reset: 30 us
// - Register write hit: full write cycle time
// - Subsector erase end or suspend: erase time
// - Reset in deep power-down: power-down exit time
// - Protection or password program: program time
// - Software reset from standby: 40 ns recovery
// - Software reset during array operation: 30 us
// - Program/subsector suspend within 25/30 us, reads accepted
// - Erase suspended: reject erases, register writes, OTP

package fts_pkg;

	// ----------------------------------------------------------------
	// Clock and counter widths
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int CNT_W = 27;

	// Least time to whole cycles, never below one
	function automatic int ns_to_cyc(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction

	function automatic int us_to_cyc(input int us);
		return ns_to_cyc(us * 1000);
	endfunction

	// ----------------------------------------------------------------
	// Times in ns and us
	// ----------------------------------------------------------------
	localparam int RST_PULSE_NS = 50;
	localparam int RECOV_SHORT_NS = 40;
	localparam int RECOV_ARRAY_US = 30;
	localparam int T_WRSR_US = 8000;
	localparam int T_WNVCR_US = 1000000;
	localparam int T_SSE_US = 400000;
	localparam int T_RDP_US = 30;
	localparam int T_ASPP_US = 500;
	localparam int T_PASSP_US = 800;
	localparam int SUSP_PGM_MAX_US = 25;
	localparam int SUSP_ERS_MAX_US = 30;
	localparam int SUSP_PGM_TYP_US = 7;
	localparam int SUSP_ERS_TYP_US = 15;
	localparam int GAP_PGM_US = 5;
	localparam int GAP_SSE_US = 50;
	localparam int GAP_SE_US = 150;

	// ----------------------------------------------------------------
	// Cycle counts
	// ----------------------------------------------------------------
	localparam int RST_PULSE_CYC = ns_to_cyc(RST_PULSE_NS);
	localparam int RECOV_SHORT_CYC = ns_to_cyc(RECOV_SHORT_NS);
	localparam int RECOV_ARRAY_CYC = us_to_cyc(RECOV_ARRAY_US);
	localparam int T_RDP_CYC = us_to_cyc(T_RDP_US);
	localparam int T_WRSR_CYC = us_to_cyc(T_WRSR_US);
	localparam int T_WNVCR_CYC = us_to_cyc(T_WNVCR_US);
	localparam int T_SSE_CYC = us_to_cyc(T_SSE_US);
	localparam int T_ASPP_CYC = us_to_cyc(T_ASPP_US);
	localparam int T_PASSP_CYC = us_to_cyc(T_PASSP_US);
	localparam int SUSP_PGM_CYC = us_to_cyc(SUSP_PGM_TYP_US);
	localparam int SUSP_ERS_CYC = us_to_cyc(SUSP_ERS_TYP_US);
	localparam int GAP_PGM_CYC = us_to_cyc(GAP_PGM_US);
	localparam int GAP_SSE_CYC = us_to_cyc(GAP_SSE_US);
	localparam int GAP_SE_CYC = us_to_cyc(GAP_SE_US);

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		OP_STANDBY,
		OP_EXECUTE_IN_PLACE,
		OP_VOLATILE,
		OP_ARRAY,
		OP_WRSR,
		OP_WRNVCR,
		OP_SSE_END,
		OP_DPD,
		OP_ASPP,
		OP_PASSP
	} fts_op_t;

	typedef enum logic [2:0] {
		CMD_READ,
		CMD_ERASE,
		CMD_WRSR,
		CMD_WRNVCR,
		CMD_OTP_PGM,
		CMD_OTHER
	} fts_cmd_t;

	typedef enum logic [1:0] {
		SUSP_PGM,
		SUSP_SSE,
		SUSP_SE
	} fts_susp_t;

	typedef enum {
		ST_READY,
		ST_RST_LOW,
		ST_RECOVER,
		ST_SUSP_WAIT,
		ST_SUSPENDED
	} fts_st_t;

endpackage

// *** hdl/fts_seq.sv ***
`timescale 1ns/1ns
`default_nettype none

module fts_seq
	import fts_pkg::*;
#(
	parameter int T_WRSR_CNT = T_WRSR_CYC,
	parameter int T_WNVCR_CNT = T_WNVCR_CYC,
	parameter int T_SSE_CNT = T_SSE_CYC,
	parameter int T_ASPP_CNT = T_ASPP_CYC,
	parameter int T_PASSP_CNT = T_PASSP_CYC
) (
	input wire logic CLK_I,             // System clock, 100 MHz
	input wire logic RST_B_I,           // Async reset, active low
	input wire logic RESET_PIN_B_I,     // Hardware reset pin, active low
	input wire logic SEL_B_I,           // Chip select pin, active low
	input wire logic [3:0] OP_I,        // Operation now running (fts_op_t)
	input wire logic SW_RESET_I,        // Software reset sequence done, pulse
	input wire logic SUSP_REQ_I,        // Suspend command, pulse
	input wire logic [1:0] SUSP_KIND_I, // Kind being suspended (fts_susp_t)
	input wire logic RESUME_I,          // Resume command, pulse
	input wire logic CMD_VALID_I,       // Decoded command, pulse
	input wire logic [2:0] CMD_CLASS_I, // Command class (fts_cmd_t)
	output logic READY_O,               // Device selectable
	output logic RESETTING_O,           // In reset or recovery
	output logic SUSPENDED_O,           // Operation suspended
	output logic [1:0] SUSP_KIND_O,     // Kind held in suspend
	output logic CMD_ACCEPT_O,          // Command accepted, pulse
	output logic CMD_REJECT_O,          // Command refused, pulse
	output logic SEL_EARLY_O            // Select ignored in recovery, pulse
);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic rstp_meta_r;
	logic rstp_sync_r;
	logic sel_meta_r;
	logic sel_sync_r;
	logic sel_prev_r;

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			rstp_meta_r <= 1'b1;
			rstp_sync_r <= 1'b1;
			sel_meta_r <= 1'b1;
			sel_sync_r <= 1'b1;
			sel_prev_r <= 1'b1;
		end else begin
			rstp_meta_r <= RESET_PIN_B_I;
			rstp_sync_r <= rstp_meta_r;
			sel_meta_r <= SEL_B_I;
			sel_sync_r <= sel_meta_r;
			sel_prev_r <= sel_sync_r;
		end
	end

	logic sel_fall;
	assign sel_fall = sel_prev_r && !sel_sync_r;

	// ----------------------------------------------------------------
	// Recovery time per interrupted operation
	// ----------------------------------------------------------------
	function automatic logic [CNT_W-1:0] recov_cnt(input logic [3:0] op,
		input logic sw);
		logic [CNT_W-1:0] n;
		n = CNT_W'(RECOV_SHORT_CYC);
		unique case (fts_op_t'(op))
			OP_STANDBY: n = CNT_W'(RECOV_SHORT_CYC);
			OP_EXECUTE_IN_PLACE: n = CNT_W'(RECOV_SHORT_CYC);
			OP_VOLATILE: n = CNT_W'(RECOV_SHORT_CYC);
			OP_ARRAY: n = CNT_W'(RECOV_ARRAY_CYC);
			OP_WRSR: n = CNT_W'(T_WRSR_CNT);
			OP_WRNVCR: n = CNT_W'(T_WNVCR_CNT);
			OP_SSE_END: n = CNT_W'(T_SSE_CNT);
			OP_DPD: n = CNT_W'(T_RDP_CYC);
			OP_ASPP: n = CNT_W'(T_ASPP_CNT);
			OP_PASSP: n = CNT_W'(T_PASSP_CNT);
			default: n = sw ? CNT_W'(RECOV_ARRAY_CYC) : CNT_W'(RECOV_ARRAY_CYC);
		endcase
		return n;
	endfunction

	// ----------------------------------------------------------------
	// Timer
	// ----------------------------------------------------------------
	fts_timer_if tif ();

	fts_timer u_timer (
		.clk_i(CLK_I),
		.rst_b_i(RST_B_I),
		.tif(tif.tmr)
	);

	// ----------------------------------------------------------------
	// Reset pulse qualification
	// ----------------------------------------------------------------
	// Short pulses are dropped: the outcome is undefined for the host
	// anyway, and ignoring them keeps a running operation intact.
	logic [3:0] low_cnt_r;
	logic low_ok_r;
	logic [3:0] op_cap_r;

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			low_cnt_r <= 4'h0;
			low_ok_r <= 1'b0;
		end else if (rstp_sync_r) begin
			low_cnt_r <= 4'h0;
			low_ok_r <= 1'b0;
		end else begin
			if (low_cnt_r != 4'hF) begin
				low_cnt_r <= low_cnt_r + 4'h1;
			end
			if (low_cnt_r >= 4'(RST_PULSE_CYC - 1)) begin
				low_ok_r <= 1'b1;
			end
		end
	end

	// Operation caught at the start of the pulse
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			op_cap_r <= 4'h0;
		end else if (rstp_sync_r) begin
			op_cap_r <= OP_I;
		end
	end

	// ----------------------------------------------------------------
	// Main sequencer
	// ----------------------------------------------------------------
	fts_st_t st_r;
	fts_st_t st_nxt;
	logic [1:0] kind_r;
	logic load_nxt;
	logic [CNT_W-1:0] load_val_nxt;

	always_comb begin
		st_nxt = st_r;
		load_nxt = 1'b0;
		load_val_nxt = '0;
		if (low_ok_r) begin
			st_nxt = ST_RST_LOW;
		end else begin
			unique case (st_r)
				ST_RST_LOW: begin
					if (rstp_sync_r) begin
						st_nxt = ST_RECOVER;
						load_nxt = 1'b1;
						load_val_nxt = recov_cnt(op_cap_r, 1'b0);
					end
				end
				ST_RECOVER: begin
					// Never stall here if the timer has gone idle
					if (tif.done || !tif.running) begin
						st_nxt = ST_READY;
					end
				end
				ST_READY, ST_SUSP_WAIT, ST_SUSPENDED: begin
					if (SW_RESET_I) begin
						st_nxt = ST_RECOVER;
						load_nxt = 1'b1;
						load_val_nxt = recov_cnt(OP_I, 1'b1);
					end else if (st_r == ST_READY && SUSP_REQ_I) begin
						// Spacing since resume is not checked here
						st_nxt = ST_SUSP_WAIT;
						load_nxt = 1'b1;
						load_val_nxt = (fts_susp_t'(SUSP_KIND_I) == SUSP_PGM) ?
							CNT_W'(SUSP_PGM_CYC) : CNT_W'(SUSP_ERS_CYC);
					end else if (st_r == ST_SUSP_WAIT && tif.done) begin
						st_nxt = ST_SUSPENDED;
					end else if (st_r == ST_SUSPENDED && RESUME_I) begin
						st_nxt = ST_READY;
					end
				end
			endcase
		end
	end

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			st_r <= ST_READY;
		end else begin
			st_r <= st_nxt;
		end
	end

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			kind_r <= 2'h0;
		end else if (st_r == ST_READY && SUSP_REQ_I && !SW_RESET_I) begin
			kind_r <= SUSP_KIND_I;
		end
	end

	assign tif.load = load_nxt;
	assign tif.load_val = load_val_nxt;

	// ----------------------------------------------------------------
	// Command filter while suspended
	// ----------------------------------------------------------------
	function automatic logic cmd_allowed(input logic [1:0] kind,
		input logic [2:0] cls);
		logic ok;
		ok = 1'b1;
		if (fts_susp_t'(kind) == SUSP_SE) begin
			unique case (fts_cmd_t'(cls))
				CMD_ERASE, CMD_WRSR, CMD_WRNVCR, CMD_OTP_PGM: ok = 1'b0;
				default: ok = 1'b1;
			endcase
		end else begin
			ok = (fts_cmd_t'(cls) == CMD_READ);
		end
		return ok;
	endfunction

	logic acc_nxt;
	logic rej_nxt;

	always_comb begin
		acc_nxt = 1'b0;
		rej_nxt = 1'b0;
		if (CMD_VALID_I) begin
			unique case (st_r)
				ST_READY: acc_nxt = 1'b1;
				ST_SUSPENDED: begin
					acc_nxt = cmd_allowed(kind_r, CMD_CLASS_I);
					rej_nxt = !acc_nxt;
				end
				default: rej_nxt = 1'b1;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			READY_O <= 1'b1;
			RESETTING_O <= 1'b0;
			SUSPENDED_O <= 1'b0;
			SUSP_KIND_O <= 2'h0;
			CMD_ACCEPT_O <= 1'b0;
			CMD_REJECT_O <= 1'b0;
			SEL_EARLY_O <= 1'b0;
		end else begin
			READY_O <= (st_nxt == ST_READY) || (st_nxt == ST_SUSPENDED)
				|| (st_nxt == ST_SUSP_WAIT);
			RESETTING_O <= (st_nxt == ST_RST_LOW) || (st_nxt == ST_RECOVER);
			SUSPENDED_O <= (st_nxt == ST_SUSPENDED);
			SUSP_KIND_O <= kind_r;
			CMD_ACCEPT_O <= acc_nxt;
			CMD_REJECT_O <= rej_nxt;
			// Select during recovery is ignored by the device
			SEL_EARLY_O <= sel_fall &&
				((st_r == ST_RST_LOW) || (st_r == ST_RECOVER));
		end
	end

endmodule // fts_seq

`default_nettype wire

// *** hdl/fts_timer.sv ***
`timescale 1ns/1ns
`default_nettype none

// Loaded with N, pulses done N edges after the load edge
module fts_timer
	import fts_pkg::*;
(
	input wire logic clk_i,     // System clock
	input wire logic rst_b_i,   // Async reset, active low
	fts_timer_if.tmr tif        // Load and done
);

	logic [CNT_W-1:0] cnt_r;
	logic run_r;
	logic done_r;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_r <= '0;
			run_r <= 1'b0;
			done_r <= 1'b0;
		end else if (tif.load) begin
			cnt_r <= tif.load_val;
			run_r <= 1'b1;
			done_r <= 1'b0;
		end else if (run_r && cnt_r <= CNT_W'(1)) begin
			cnt_r <= '0;
			run_r <= 1'b0;
			done_r <= 1'b1;
		end else begin
			cnt_r <= run_r ? cnt_r - CNT_W'(1) : cnt_r;
			done_r <= 1'b0;
		end
	end

	assign tif.done = done_r;
	assign tif.running = run_r;

endmodule // fts_timer

`default_nettype wire

// *** hdl/fts_timer_if.sv ***
`timescale 1ns/1ns
`default_nettype none

interface fts_timer_if;
	import fts_pkg::*;

	logic load;
	logic [CNT_W-1:0] load_val;
	logic done;
	logic running;

	modport ctrl (output load, output load_val, input done, input running);
	modport tmr (input load, input load_val, output done, output running);

endinterface

`default_nettype wire

// *** verification/fts_host_model.sv ***
`timescale 1ns/1ns
`default_nettype none

module fts_host_model (
	input wire logic clk_i, // System clock
	input wire logic ready_i, // Device selectable
	input wire logic sel_early_i, // Early select flag
	output logic reset_pin_b_o, // Reset pin, active low
	output logic sel_b_o, // Select, active low
	output logic link_clk_o // Link clock, still outside frames
);
	initial begin
		reset_pin_b_o = 1'b1;
		sel_b_o = 1'b1;
		link_clk_o = 1'b0;
	end

	task automatic pulse_reset(input int n);
		@(posedge clk_i);
		reset_pin_b_o <= 1'b0;
		repeat (n) @(posedge clk_i);
		reset_pin_b_o <= 1'b1;
	endtask

	// Early frames skip the wait to provoke the refusal
	task automatic frame(input bit early, output bit seen);
		seen = 1'b0;
		if (!early)
			wait (ready_i === 1'b1);
		@(posedge clk_i);
		sel_b_o <= 1'b0;
		for (int i = 0; i < 64; i++) begin
			@(posedge clk_i);
			#1;
			seen |= sel_early_i;
			if (i % 4 == 3)
				link_clk_o <= ~link_clk_o;
		end
		@(posedge clk_i);
		sel_b_o <= 1'b1;
	endtask

endmodule // fts_host_model

`default_nettype wire

// *** verification/fts_seq_monitor.sv ***
`timescale 1ns/1ns
`default_nettype none

module fts_seq_monitor
	import fts_pkg::*;
(
	input wire logic CLK_I, // Clock
	input wire logic RST_B_I, // Reset, active low
	input wire logic [3:0] OP_I, // Running op
	input wire logic SW_RESET_I, // Soft reset
	input wire logic SUSP_REQ_I, // Suspend request
	input wire logic CMD_VALID_I, // Command
	input wire logic [2:0] CMD_CLASS_I, // Command class
	input wire logic READY_O, // Selectable
	input wire logic RESETTING_O, // Recovering
	input wire logic SUSPENDED_O, // Suspended
	input wire logic [1:0] SUSP_KIND_O, // Held kind
	input wire logic CMD_ACCEPT_O, // Accept pulse
	input wire logic CMD_REJECT_O // Reject pulse
);
	localparam int RA = RECOV_ARRAY_CYC;
	localparam int SP = SUSP_PGM_CYC + 1;
	localparam int SE = SUSP_ERS_CYC + 1;
	logic [15:0] rcnt_r;
	logic [15:0] scnt_r;
	logic arr_r;
	wire sw_go = SW_RESET_I && READY_O && !RESETTING_O;
	wire ers = CMD_CLASS_I inside {CMD_ERASE, CMD_WRSR, CMD_WRNVCR, CMD_OTP_PGM};

	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RST_B_I);

	// ----------------------------------------------------------------
	// Helper counters
	// ----------------------------------------------------------------
	// Flag is dropped one edge after the fall so the assertion still sees it
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			rcnt_r <= 16'h0;
			arr_r <= 1'b0;
		end else begin
			rcnt_r <= RESETTING_O ? rcnt_r + 16'h1 : 16'h0;
			if (sw_go)
				arr_r <= (OP_I == OP_ARRAY);
			else if (!RESETTING_O && rcnt_r != 16'h0)
				arr_r <= 1'b0;
		end
	end

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I)
			scnt_r <= 16'h0;
		else if (RESETTING_O || SUSPENDED_O)
			scnt_r <= 16'h0;
		else if (scnt_r != 16'h0)
			scnt_r <= scnt_r + 16'h1;
		else if (SUSP_REQ_I && READY_O)
			scnt_r <= 16'h1;
	end

	sequence sw_short_s;
		sw_go && OP_I == OP_STANDBY;
	endsequence

	sequence short_recov_s;
		!READY_O [*4] ##[1:3] READY_O;
	endsequence

	a_cmd_answered: assert property (
		CMD_VALID_I |=> CMD_ACCEPT_O != CMD_REJECT_O)
		else $error("command not answered once");
	a_no_stray_answer: assert property (
		!CMD_VALID_I |=> !CMD_ACCEPT_O && !CMD_REJECT_O)
		else $error("answer without command");
	a_susp_filter: assert property (
		SUSPENDED_O && CMD_VALID_I && (SUSP_KIND_O == SUSP_SE ? ers :
		CMD_CLASS_I != CMD_READ) |=> CMD_REJECT_O)
		else $error("forbidden command taken in suspend");
	a_susp_read_ok: assert property (
		SUSPENDED_O && CMD_VALID_I && CMD_CLASS_I == CMD_READ |=> CMD_ACCEPT_O)
		else $error("read refused in suspend");
	a_erase_susp_ok: assert property (
		SUSPENDED_O && SUSP_KIND_O == SUSP_SE && CMD_VALID_I && !ers
		|=> CMD_ACCEPT_O)
		else $error("allowed command refused in erase suspend");
	a_reset_blocks: assert property (
		RESETTING_O |-> !READY_O)
		else $error("ready during recovery");
	a_sw_start: assert property (
		sw_go |=> RESETTING_O && !READY_O)
		else $error("soft reset not started");
	a_sw_short: assert property (
		sw_short_s |=> short_recov_s)
		else $error("short soft recovery wrong");
	a_array_recov: assert property (
		$fell(RESETTING_O) && arr_r |-> rcnt_r inside {[RA - 1:RA + 3]})
		else $error("array soft recovery wrong");
	a_susp_latency: assert property (
		$rose(SUSPENDED_O) |-> (SUSP_KIND_O == SUSP_PGM ?
		scnt_r inside {[SP - 2:SP + 2]} : scnt_r inside {[SE - 2:SE + 2]}))
		else $error("suspend latency wrong");

endmodule // fts_seq_monitor

`default_nettype wire

// *** verification/testbench.sv ***
`timescale 1ns/1ns
`default_nettype none

module testbench
	import fts_pkg::*;
();
	localparam int P = 20;
	logic CLK_I = 1'b0;
	logic RST_B_I, SW_RESET_I, SUSP_REQ_I, RESUME_I, CMD_VALID_I;
	logic [3:0] OP_I;
	logic [1:0] SUSP_KIND_I, SUSP_KIND_O;
	logic [2:0] CMD_CLASS_I;
	logic READY_O, RESETTING_O, SUSPENDED_O, CMD_ACCEPT_O, CMD_REJECT_O;
	logic SEL_EARLY_O, pin_b, sel_b, link_clk;
	int n_mismatch = 0;
	int tests_run = 0;
	int n, n0;
	int q[$];
	int unsigned seed = 78855;
	bit seen;

	fts_seq #(.T_WRSR_CNT(P), .T_WNVCR_CNT(P), .T_SSE_CNT(P),
		.T_ASPP_CNT(P), .T_PASSP_CNT(P)) dut_u (.CLK_I(CLK_I),
		.RST_B_I(RST_B_I), .RESET_PIN_B_I(pin_b), .SEL_B_I(sel_b),
		.OP_I(OP_I), .SW_RESET_I(SW_RESET_I), .SUSP_REQ_I(SUSP_REQ_I),
		.SUSP_KIND_I(SUSP_KIND_I), .RESUME_I(RESUME_I),
		.CMD_VALID_I(CMD_VALID_I), .CMD_CLASS_I(CMD_CLASS_I),
		.READY_O(READY_O), .RESETTING_O(RESETTING_O),
		.SUSPENDED_O(SUSPENDED_O), .SUSP_KIND_O(SUSP_KIND_O),
		.CMD_ACCEPT_O(CMD_ACCEPT_O), .CMD_REJECT_O(CMD_REJECT_O),
		.SEL_EARLY_O(SEL_EARLY_O));

	fts_host_model host_u (.clk_i(CLK_I), .ready_i(READY_O),
		.sel_early_i(SEL_EARLY_O), .reset_pin_b_o(pin_b),
		.sel_b_o(sel_b), .link_clk_o(link_clk));

	always #5 CLK_I = ~CLK_I;

	function automatic int unsigned rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic check(input logic [31:0] got, exp, input int tol);
		logic bad;
		tests_run++;
		if (tol == 0)
			bad = (got !== exp);
		else
			bad = $isunknown(got) || got > exp + tol || got + tol < exp;
		if (bad) begin
			n_mismatch++;
			$display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask

	task automatic final_report();
		$display("mismatches %0d of %0d checks", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	function automatic int recov(input int op);
		case (op)
			OP_STANDBY, OP_EXECUTE_IN_PLACE, OP_VOLATILE:
				return RECOV_SHORT_CYC;
			OP_ARRAY: return RECOV_ARRAY_CYC;
			OP_DPD: return T_RDP_CYC;
			default: return P;
		endcase
	endfunction

	function automatic int exp_acc(input bit susp, input int kind, cls);
		if (!susp)
			return 1;
		if (kind == SUSP_SE)
			return !(cls inside {CMD_ERASE, CMD_WRSR, CMD_WRNVCR, CMD_OTP_PGM});
		return cls == CMD_READ;
	endfunction

	// Bounded wait for ready or suspended, counting edges
	task automatic wait_for(input bit susp, input int lim, output int k);
		k = 0;
		while ((susp ? SUSPENDED_O : READY_O) !== 1'b1 && k < lim) begin
			@(posedge CLK_I);
			#1;
			k++;
		end
	endtask

	task automatic round(input bit susp, input int kind);
		int ofs;
		int c;
		ofs = rnd() % 6;
		for (int i = 0; i < 6; i++) begin
			c = (i + ofs) % 6;
			q.push_back(exp_acc(susp, kind, c) ? 1 : 2);
			@(posedge CLK_I);
			CMD_VALID_I <= 1'b1;
			CMD_CLASS_I <= 3'(c);
			@(posedge CLK_I);
			CMD_VALID_I <= 1'b0;
			#1;
			check({CMD_REJECT_O, CMD_ACCEPT_O}, q.pop_front(), 0);
		end
	endtask

	initial begin
		RST_B_I = 1'b0;
		{SW_RESET_I, SUSP_REQ_I, RESUME_I, CMD_VALID_I} = 4'h0;
		OP_I = 4'h0;
		SUSP_KIND_I = 2'h0;
		CMD_CLASS_I = 3'h0;
		repeat (16) @(posedge CLK_I);
		RST_B_I <= 1'b1;
		round(1'b0, 0);
		for (int op = 0; op < 10; op++) begin
			@(posedge CLK_I);
			OP_I <= 4'(op);
			host_u.pulse_reset(10);
			#1;
			check(RESETTING_O, 1, 0);
			n0 = 0;
			if (op == OP_DPD) begin
				host_u.frame(1'b1, seen);
				#1;
				check(seen, 1, 0);
				n0 = 66;
			end
			wait_for(1'b0, 9000, n);
			// Two sync flops, flag clear, timer load and output register
			check(n0 + n, recov(op) + 5, 1);
		end
		for (int k = 0; k < 2; k++) begin
			@(posedge CLK_I);
			OP_I <= k ? OP_ARRAY : OP_STANDBY;
			SW_RESET_I <= 1'b1;
			@(posedge CLK_I);
			SW_RESET_I <= 1'b0;
			#1;
			check(RESETTING_O, 1, 0);
			wait_for(1'b0, 4000, n);
			check(n, recov(k ? OP_ARRAY : OP_STANDBY) + 1, 1);
		end
		// A pulse below the least width must leave the device alone
		host_u.pulse_reset(2);
		repeat (8) @(posedge CLK_I);
		#1;
		check(RESETTING_O, 0, 0);
		check(READY_O, 1, 0);
		// Host keeps the start or resume to suspend spacing itself
		for (int k = 0; k < 3; k++) begin
			n = (k == SUSP_PGM) ? GAP_PGM_CYC : (k == SUSP_SSE) ?
				GAP_SSE_CYC : GAP_SE_CYC;
			repeat (n) @(posedge CLK_I);
			SUSP_KIND_I <= 2'(k);
			SUSP_REQ_I <= 1'b1;
			@(posedge CLK_I);
			SUSP_REQ_I <= 1'b0;
			#1;
			wait_for(1'b1, 3100, n);
			check(n, k == SUSP_PGM ? SUSP_PGM_CYC : SUSP_ERS_CYC, 2);
			check(SUSP_KIND_O, k, 0);
			round(1'b1, k);
			@(posedge CLK_I);
			RESUME_I <= 1'b1;
			@(posedge CLK_I);
			RESUME_I <= 1'b0;
			@(posedge CLK_I);
			#1;
			check(SUSPENDED_O, 0, 0);
		end
		host_u.frame(1'b0, seen);
		check(seen, 0, 0);
		check(link_clk, 0, 0);
		final_report();
	end

	initial begin
		repeat (80000) @(posedge CLK_I);
		n_mismatch++;
		final_report();
	end

endmodule // testbench

bind fts_seq fts_seq_monitor mon_u (.CLK_I(CLK_I), .RST_B_I(RST_B_I),
	.OP_I(OP_I), .SW_RESET_I(SW_RESET_I), .SUSP_REQ_I(SUSP_REQ_I),
	.CMD_VALID_I(CMD_VALID_I), .CMD_CLASS_I(CMD_CLASS_I),
	.READY_O(READY_O), .RESETTING_O(RESETTING_O),
	.SUSPENDED_O(SUSPENDED_O), .SUSP_KIND_O(SUSP_KIND_O),
	.CMD_ACCEPT_O(CMD_ACCEPT_O), .CMD_REJECT_O(CMD_REJECT_O));

`default_nettype wire
